// ---- verilog/dual_timer_counter_clockout.v ----
// Two 16-bit timer/counters with clock-out, behind a Wishbone slave
//
// Contract
// - Timer ticks every twelve clocks, or every clock when fast bit set and timer_a slow bit clear.
// - Timer_a rate from {slow,fast}: /12, /1, /48, /192.
// - Counter function samples pin each rate tick, counts high-then-low.
// - Detected fall shows in count at end of following rate tick.
// - Mode 0 is 8-bit PWM; wrap from all ones sets flag.
// - Counting only while run set and gating off or gate pin high; split timer_a high byte needs only timer_b run, no gating.
// - Mode 1 counts full 16 bits with same gating.
// - Mode 2 low byte reloads from high byte on overflow, sets flag.
// - Timer_b in mode 3 stops and holds its count.
// - Timer_a mode 3: two bytes; high byte uses timer_b run and flag.
// - Timer source and clock-out enable: auto-reload, 50% square wave.
// - Timer_b clock-out clocked only by /12 or undivided clock.
// - Timer_b clock-out is clock over n(256-reload), n 24 or 2.
// - Timer_a clock-out n is 24 for pair 00, 384 for pair 11.
// - Clock-out overflows set flag but never request interrupt.
// - Timer_b gives baud tick and clock-out from one overflow rate.
// - Flag cleared on interrupt vectoring; software may set or clear.
`include "timer_pair_defs.vh"

module dual_timer_counter_clockout (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rstn,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // External pins
    input  wire        count_pin_a,
    input  wire        count_pin_b,
    input  wire        external_gate_input_a,
    input  wire        external_gate_input_b,
    output reg         timer_a_clkout_pin,
    output reg         timer_b_clkout_pin,
    // Processor interrupt side
    input  wire        vector_ack_a,
    input  wire        vector_ack_b,
    output reg         overflow_flag_a,
    output reg         overflow_flag_b,
    output reg         baud_tick_b,
    output reg         irq
);

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    reg  [1:0]  run_reg;
    reg  [7:0]  mode_reg;
    reg  [4:0]  clkcfg_reg;
    reg  [7:0]  low_a_reg;
    reg  [7:0]  high_a_reg;
    reg  [7:0]  low_b_reg;
    reg  [7:0]  high_b_reg;
    reg  [1:0]  int_status_reg;
    reg  [1:0]  int_mask_reg;
    reg  [3:0]  pre_cnt_reg;
    reg  [3:0]  sub_cnt_reg;

    reg  [7:0]  low_a_next;
    reg  [7:0]  high_a_next;
    reg  [7:0]  low_b_next;
    reg  [7:0]  high_b_next;
    reg  [1:0]  flag_next;
    reg  [1:0]  int_status_next;
    reg         ovf_a;
    reg         ovf_a_high;
    reg         ovf_b;
    reg  [31:0] rd_data;

    // Field views
    wire [1:0]  mode_a      = mode_reg[`MODE_A_HI:`MODE_A_LO];
    wire [1:0]  mode_b      = mode_reg[`MODE_B_HI:`MODE_B_LO];
    wire        src_a       = mode_reg[`MODE_SRC_A];
    wire        src_b       = mode_reg[`MODE_SRC_B];
    wire        gate_en_a   = mode_reg[`MODE_GATE_A];
    wire        gate_en_b   = mode_reg[`MODE_GATE_B];
    wire        timer_a_fast_clock    = clkcfg_reg[`CLK_FAST_A];
    wire        timer_a_slow_prescale = clkcfg_reg[`CLK_SLOW_A];
    wire        timer_b_fast_clock    = clkcfg_reg[`CLK_FAST_B];
    wire        timer_a_clkout_enable = clkcfg_reg[`CLK_CKOE_A];
    wire        timer_b_clkout_enable = clkcfg_reg[`CLK_CKOE_B];

    // Clock-out mode forces auto-reload regardless of the mode field
    wire        clko_a = ~src_a & timer_a_clkout_enable;
    wire        clko_b = ~src_b & timer_b_clkout_enable;
    wire [1:0]  mode_a_eff = clko_a ? `MODE_RELOAD8 : mode_a;
    wire [1:0]  mode_b_eff = clko_b ? `MODE_RELOAD8 : mode_b;
    wire        split_a = (mode_a_eff == `MODE_SPLIT);

    // ----------------------------------------------------------------
    // Bus request decode
    // ----------------------------------------------------------------
    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr  = bus_req & wb_we_i;
    wire        wr_ctrl   = bus_wr & wb_sel_i[0] & (wb_adr_i == `OFS_CTRL);
    wire        wr_mode   = bus_wr & wb_sel_i[0] & (wb_adr_i == `OFS_MODE);
    wire        wr_clkcfg = bus_wr & wb_sel_i[0] & (wb_adr_i == `OFS_CLKCFG);
    wire        wr_cnt_a  = bus_wr & (wb_adr_i == `OFS_COUNT_A);
    wire        wr_cnt_b  = bus_wr & (wb_adr_i == `OFS_COUNT_B);
    wire        wr_stat   = bus_wr & wb_sel_i[0] &
                            (wb_adr_i == `OFS_INT_STATUS);
    wire        wr_mask   = bus_wr & wb_sel_i[0] &
                            (wb_adr_i == `OFS_INT_MASK);

    // ----------------------------------------------------------------
    // Prescaler: /12 base, /48 and /192 from a second stage
    // ----------------------------------------------------------------
    wire tick12  = (pre_cnt_reg == `PRE_DIV12_LAST);
    wire tick48  = tick12 & (sub_cnt_reg[1:0] == `PRE_DIV48_LAST);
    wire tick192 = tick12 & (sub_cnt_reg == `PRE_DIV192_LAST);

    // Divider counters
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt_reg <= 4'h0;
            sub_cnt_reg <= 4'h0;
        end else begin
            pre_cnt_reg <= tick12 ? 4'h0 : pre_cnt_reg + 4'h1;
            if (tick12) begin
                sub_cnt_reg <= sub_cnt_reg + 4'h1;
            end
        end
    end

    // Rate tick per timer
    reg tick_a;
    always @* begin
        case ({timer_a_slow_prescale, timer_a_fast_clock})
            2'b00:   tick_a = tick12;
            2'b01:   tick_a = 1'b1;
            2'b10:   tick_a = tick48;
            default: tick_a = tick192;
        endcase
    end
    // Timer_b has only the /12 and undivided choices
    wire tick_b = timer_b_fast_clock ? 1'b1 : tick12;

    // ----------------------------------------------------------------
    // Pin synchronisers and falling-edge sampling per timer
    // ----------------------------------------------------------------
    wire [1:0] cnt_pins  = {count_pin_b, count_pin_a};
    wire [1:0] gate_pins = {external_gate_input_b, external_gate_input_a};
    wire [1:0] ticks     = {tick_b, tick_a};
    wire [1:0] gate_s;
    wire [1:0] fall_evt;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            reg [1:0] cnt_sync_reg;
            reg [1:0] gate_sync_reg;
            reg       sample_reg;
            reg       pend_reg;
            // Two-stage sync, then sample once per rate tick
            always @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_sync_reg  <= 2'b00;
                    gate_sync_reg <= 2'b00;
                    sample_reg    <= 1'b0;
                    pend_reg      <= 1'b0;
                end else begin
                    cnt_sync_reg  <= {cnt_sync_reg[0], cnt_pins[gi]};
                    gate_sync_reg <= {gate_sync_reg[0], gate_pins[gi]};
                    if (ticks[gi]) begin
                        sample_reg <= cnt_sync_reg[1];
                        pend_reg   <= sample_reg & ~cnt_sync_reg[1];
                    end
                end
            end
            assign gate_s[gi]   = gate_sync_reg[1];
            // Count applied one rate tick after detection
            assign fall_evt[gi] = ticks[gi] & pend_reg;
        end
    endgenerate

    // Gated counting input
    wire en_a  = run_reg[0] & (~gate_en_a | gate_s[0]);
    wire en_b  = run_reg[1] & (~gate_en_b | gate_s[1]);
    wire inc_a = en_a & (src_a ? fall_evt[0] : tick_a);
    wire inc_b = en_b & (src_b ? fall_evt[1] : tick_b);
    // High byte of a split timer counts internal ticks on b's run bit
    wire inc_ah = split_a & run_reg[1] & tick_a;

    // ----------------------------------------------------------------
    // Timer_a next count
    // ----------------------------------------------------------------
    always @* begin
        low_a_next  = low_a_reg;
        high_a_next = high_a_reg;
        ovf_a       = 1'b0;
        ovf_a_high  = 1'b0;
        if (inc_a) begin
            case (mode_a_eff)
                `MODE_CNT16: begin
                    {high_a_next, low_a_next} =
                        {high_a_reg, low_a_reg} + 16'h0001;
                    ovf_a = (low_a_reg == 8'hff) & (high_a_reg == 8'hff);
                end
                `MODE_RELOAD8: begin
                    if (low_a_reg == 8'hff) begin
                        low_a_next = high_a_reg;
                        ovf_a      = 1'b1;
                    end else begin
                        low_a_next = low_a_reg + 8'h01;
                    end
                end
                default: begin
                    low_a_next = low_a_reg + 8'h01;
                    ovf_a      = (low_a_reg == 8'hff);
                end
            endcase
        end
        if (inc_ah) begin
            high_a_next = high_a_reg + 8'h01;
            ovf_a_high  = (high_a_reg == 8'hff);
        end
        if (wr_cnt_a && wb_sel_i[0]) begin
            low_a_next = wb_dat_i[7:0];
        end
        if (wr_cnt_a && wb_sel_i[1]) begin
            high_a_next = wb_dat_i[15:8];
        end
    end

    // ----------------------------------------------------------------
    // Timer_b next count
    // ----------------------------------------------------------------
    always @* begin
        low_b_next  = low_b_reg;
        high_b_next = high_b_reg;
        ovf_b       = 1'b0;
        if (inc_b) begin
            case (mode_b_eff)
                `MODE_CNT16: begin
                    {high_b_next, low_b_next} =
                        {high_b_reg, low_b_reg} + 16'h0001;
                    ovf_b = (low_b_reg == 8'hff) & (high_b_reg == 8'hff);
                end
                `MODE_RELOAD8: begin
                    if (low_b_reg == 8'hff) begin
                        low_b_next = high_b_reg;
                        ovf_b      = 1'b1;
                    end else begin
                        low_b_next = low_b_reg + 8'h01;
                    end
                end
                `MODE_SPLIT: begin
                    low_b_next = low_b_reg;
                end
                default: begin
                    low_b_next = low_b_reg + 8'h01;
                    ovf_b      = (low_b_reg == 8'hff);
                end
            endcase
        end
        if (wr_cnt_b && wb_sel_i[0]) begin
            low_b_next = wb_dat_i[7:0];
        end
        if (wr_cnt_b && wb_sel_i[1]) begin
            high_b_next = wb_dat_i[15:8];
        end
    end

    // ----------------------------------------------------------------
    // Flags and interrupt status
    // ----------------------------------------------------------------
    // Flag b belongs to a's high byte while a is split
    wire ovf_b_src = split_a ? ovf_a_high : ovf_b;
    // Clock-out overflows never raise a request
    wire req_a = ovf_a & ~clko_a;
    wire req_b = split_a ? ovf_a_high : (ovf_b & ~clko_b);

    // Clears first, hardware set last so a set is never lost
    always @* begin
        flag_next = {overflow_flag_b, overflow_flag_a};
        if (vector_ack_a) begin
            flag_next[0] = 1'b0;
        end
        if (vector_ack_b) begin
            flag_next[1] = 1'b0;
        end
        if (wr_ctrl) begin
            flag_next[0] = wb_dat_i[`CTRL_FLAG_A];
            flag_next[1] = wb_dat_i[`CTRL_FLAG_B];
        end
        if (ovf_a) begin
            flag_next[0] = 1'b1;
        end
        if (ovf_b_src) begin
            flag_next[1] = 1'b1;
        end
        int_status_next = int_status_reg;
        if (wr_stat) begin
            int_status_next = int_status_reg & ~wb_dat_i[1:0];
        end
        int_status_next = int_status_next | {req_b, req_a};
    end

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_reg         <= `RST_FLAGS;
            mode_reg        <= `RST_BYTE;
            clkcfg_reg      <= 5'h00;
            low_a_reg       <= `RST_BYTE;
            high_a_reg      <= `RST_BYTE;
            low_b_reg       <= `RST_BYTE;
            high_b_reg      <= `RST_BYTE;
            int_status_reg  <= `RST_FLAGS;
            int_mask_reg    <= `RST_FLAGS;
            overflow_flag_a <= 1'b0;
            overflow_flag_b <= 1'b0;
            irq             <= 1'b0;
            baud_tick_b     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                run_reg <= {wb_dat_i[`CTRL_RUN_B], wb_dat_i[`CTRL_RUN_A]};
            end
            if (wr_mode) begin
                mode_reg <= wb_dat_i[7:0];
            end
            if (wr_clkcfg) begin
                clkcfg_reg <= wb_dat_i[4:0];
            end
            if (wr_mask) begin
                int_mask_reg <= wb_dat_i[1:0];
            end
            low_a_reg       <= low_a_next;
            high_a_reg      <= high_a_next;
            low_b_reg       <= low_b_next;
            high_b_reg      <= high_b_next;
            overflow_flag_a <= flag_next[0];
            overflow_flag_b <= flag_next[1];
            int_status_reg  <= int_status_next;
            irq             <= |(int_status_next &
                                 (wr_mask ? wb_dat_i[1:0] : int_mask_reg));
            baud_tick_b     <= ovf_b;
        end
    end

    // ----------------------------------------------------------------
    // Clock-out pins: toggle per overflow, PWM compare in mode 0
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            timer_a_clkout_pin <= 1'b0;
            timer_b_clkout_pin <= 1'b0;
        end else begin
            if (clko_a) begin
                if (ovf_a) begin
                    // Half period per overflow gives n = 2 x prescale
                    timer_a_clkout_pin <= ~timer_a_clkout_pin;
                end
            end else if (timer_a_clkout_enable &&
                         mode_a_eff == `MODE_PWM8) begin
                timer_a_clkout_pin <= (low_a_reg >= high_a_reg);
            end else begin
                timer_a_clkout_pin <= 1'b0;
            end
            if (clko_b) begin
                if (ovf_b) begin
                    timer_b_clkout_pin <= ~timer_b_clkout_pin;
                end
            end else if (timer_b_clkout_enable &&
                         mode_b_eff == `MODE_PWM8) begin
                timer_b_clkout_pin <= (low_b_reg >= high_b_reg);
            end else begin
                timer_b_clkout_pin <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    // ----------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i == `OFS_CTRL) begin
            rd_data[`CTRL_RUN_A]  = run_reg[0];
            rd_data[`CTRL_RUN_B]  = run_reg[1];
            rd_data[`CTRL_FLAG_A] = overflow_flag_a;
            rd_data[`CTRL_FLAG_B] = overflow_flag_b;
        end else if (wb_adr_i == `OFS_MODE) begin
            rd_data[7:0] = mode_reg;
        end else if (wb_adr_i == `OFS_CLKCFG) begin
            rd_data[4:0] = clkcfg_reg;
        end else if (wb_adr_i == `OFS_COUNT_A) begin
            rd_data[15:0] = {high_a_reg, low_a_reg};
        end else if (wb_adr_i == `OFS_COUNT_B) begin
            rd_data[15:0] = {high_b_reg, low_b_reg};
        end else if (wb_adr_i == `OFS_INT_STATUS) begin
            rd_data[1:0] = int_status_reg;
        end else if (wb_adr_i == `OFS_INT_MASK) begin
            rd_data[1:0] = int_mask_reg;
        end
    end

    // Single-wait-state acknowledge
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule

// ---- verilog/timer_pair_defs.vh ----
// Register offsets, field positions and reset values of the timer pair
`ifndef TIMER_PAIR_DEFS_VH
`define TIMER_PAIR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_MODE        8'h04
`define OFS_CLKCFG      8'h08
`define OFS_COUNT_A     8'h0c
`define OFS_COUNT_B     8'h10
`define OFS_INT_STATUS  8'h14
`define OFS_INT_MASK    8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_RUN_A      0
`define CTRL_RUN_B      1
`define CTRL_FLAG_A     2
`define CTRL_FLAG_B     3

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_A_LO       0
`define MODE_A_HI       1
`define MODE_SRC_A      2
`define MODE_GATE_A     3
`define MODE_B_LO       4
`define MODE_B_HI       5
`define MODE_SRC_B      6
`define MODE_GATE_B     7

// ----------------------------------------------------------------
// Clock configuration register fields
// ----------------------------------------------------------------
`define CLK_FAST_A      0
`define CLK_SLOW_A      1
`define CLK_FAST_B      2
`define CLK_CKOE_A      3
`define CLK_CKOE_B      4

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define INT_OVF_A       0
`define INT_OVF_B       1

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define MODE_PWM8       2'd0
`define MODE_CNT16      2'd1
`define MODE_RELOAD8    2'd2
`define MODE_SPLIT      2'd3

// ----------------------------------------------------------------
// Reset values and prescaler counts
// ----------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_FLAGS       2'b00
`define PRE_DIV12_LAST  4'hb
`define PRE_DIV48_LAST  2'b11
`define PRE_DIV192_LAST 4'hf

`endif

// ---- tb/timer_pair_sva.sv ----
// Port assertions for the dual timer block
module timer_pair_sva (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Flags and interrupt
    input wire logic        vector_ack_a,
    input wire logic        vector_ack_b,
    input wire logic        overflow_flag_a,
    input wire logic        overflow_flag_b,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Request qualifiers
    wire req = wb_cyc_i && wb_stb_i;
    wire wr  = req && wb_we_i;
    chk_ack_delay: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    chk_rdata_hold: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data moved without read");
    chk_flag_hold_a: assert property (
        overflow_flag_a && !vector_ack_a && !wr |=> overflow_flag_a)
        else $error("flag a cleared by itself");
    chk_flag_hold_b: assert property (
        overflow_flag_b && !vector_ack_b && !wr |=> overflow_flag_b)
        else $error("flag b cleared by itself");
    chk_irq_drop: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without a write");
    chk_reset_quiet: assert property ($rose(rstn) |-> !wb_ack_o && !irq
        && !overflow_flag_a && !overflow_flag_b)
        else $error("outputs active after reset");
endmodule

bind dual_timer_counter_clockout timer_pair_sva u_sva (.*);

// ---- tb/pin_partner.sv ----
// Model of the external count, gate and clock-out pins
module pin_partner (
    // Clock and bench controls
    input  wire logic core_clk,
    input  wire logic pulse_en,
    input  wire logic gate_lvl,
    // Pins
    input  wire logic timer_a_clkout_pin,
    input  wire logic timer_b_clkout_pin,
    output logic      count_pin_a,
    output logic      count_pin_b,
    output logic      external_gate_input_a,
    output logic      external_gate_input_b,
    // Measurements
    output int        falls,
    output int        half_a,
    output int        half_b
);
    timeunit 1ns;
    timeprecision 1ps;
    int   ph = 0;
    int   ca = 0;
    int   cb = 0;
    logic pa = 0;
    logic pb = 0;
    initial {count_pin_a, count_pin_b, falls, half_a, half_b} = '1;
    // Square wave on count pins, idle high like a pull-up
    always @(posedge core_clk) begin
        ph <= pulse_en ? ph + 1 : 0;
        if (!pulse_en) {count_pin_a, count_pin_b} <= 2'b11;
        else if (ph % 8 == 7) begin
            {count_pin_a, count_pin_b} <= ~{count_pin_a, count_pin_b};
            falls <= falls + count_pin_a;
        end
        {external_gate_input_a, external_gate_input_b} <= {2{gate_lvl}};
    end
    // Length of the last clock-out half period
    always @(posedge core_clk) begin
        {pa, pb} <= {timer_a_clkout_pin, timer_b_clkout_pin};
        ca <= (timer_a_clkout_pin != pa) ? 1 : ca + 1;
        cb <= (timer_b_clkout_pin != pb) ? 1 : cb + 1;
        if (timer_a_clkout_pin != pa) half_a <= ca;
        if (timer_b_clkout_pin != pb) half_b <= cb;
    end
endmodule

// ---- tb/tb_dual_timer_counter_clockout.sv ----
// Self-checking bench for the dual timer block
`include "timer_pair_defs.vh"
module tb_dual_timer_counter_clockout;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic vector_ack_a = 0, vector_ack_b = 0, pulse_en = 0, gate_lvl = 1;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, lo_q[$], hi_q[$], m_q[$];
    wire [31:0] wb_dat_o;
    wire wb_ack_o, count_pin_a, count_pin_b, external_gate_input_a;
    wire external_gate_input_b, timer_a_clkout_pin, timer_b_clkout_pin;
    wire overflow_flag_a, overflow_flag_b, baud_tick_b, irq;
    int falls, half_a, half_b, v, error_cnt = 0, samples_checked = 0, cc = 0;
    int h, k, b0, nb = 0;
    int dv[4] = '{12, 1, 48, 192};
    int cf[6] = '{8, 9, 10, 11, 8'h12, 8'h16};
    int nn[6] = '{24, 2, 96, 384, 24, 2};
    always #5 core_clk = ~core_clk;
    dual_timer_counter_clockout dut (.*);
    pin_partner pp (.*);
    task automatic cmp(input logic [31:0] g, lo, hi);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t got %h want %h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi, m);
        lo_q.push_back(lo & m);
        hi_q.push_back(hi & m);
        m_q.push_back(m);
        bus(a, 0, 0);
    endtask
    task automatic wrap_up;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Read answers against the oldest note, plus the run limit
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            cmp(wb_dat_o & m_q.pop_front(), lo_q.pop_front(), hi_q.pop_front());
        if (baud_tick_b === 1'b1) nb++;
        if (++cc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        v = $urandom(54102);
        repeat (16) @(posedge core_clk);
        rstn <= 1;
        for (int a = 0; a < 32; a += 4) rd(a, 0, 0, '1);
        v = $urandom;
        bus(`OFS_MODE, 1, v[7:0]);
        rd(`OFS_MODE, v[7:0], v[7:0], 32'hff);
        bus(8'h1c, 1, v);
        rd(8'h1c, 0, 0, '1);
        bus(`OFS_MODE, 1, 1);
        for (int i = 0; i < 4; i++) begin
            bus(`OFS_CLKCFG, 1, i);
            bus(`OFS_COUNT_A, 1, 0);
            bus(`OFS_CTRL, 1, 1);
            repeat (765) @(posedge core_clk);
            bus(`OFS_CTRL, 1, 0);
            rd(`OFS_COUNT_A, 768 / dv[i] - 1, 768 / dv[i] + 1, 32'hffff);
        end
        bus(`OFS_CLKCFG, 1, 1);
        bus(`OFS_MODE, 1, 32'h0d);
        bus(`OFS_COUNT_A, 1, 0);
        bus(`OFS_CTRL, 1, 1);
        for (int g = 0; g < 2; g++) begin
            v = falls;
            gate_lvl <= g;
            pulse_en <= 1;
            repeat (160) @(posedge core_clk);
            pulse_en <= 0;
            repeat (8) @(posedge core_clk);
            k = g ? falls - v : 0;
            rd(`OFS_COUNT_A, k, k, 32'hffff);
            rd(`OFS_COUNT_A, k, k, 32'hffff);
        end
        for (int m = 0; m < 3; m += 2) begin
            v = $urandom_range(250, 253);
            bus(`OFS_INT_MASK, 1, m / 2);
            bus(`OFS_MODE, 1, m);
            bus(`OFS_COUNT_A, 1, {v[7:0], v[7:0]});
            bus(`OFS_CTRL, 1, 1);
            repeat (20) @(posedge core_clk);
            cmp({overflow_flag_a, irq}, 2 + m / 2, 2 + m / 2);
            if (m) rd(`OFS_COUNT_A, {v[7:0], v[7:0]}, {v[7:0], 8'hff}, '1);
            bus(`OFS_CTRL, 1, 0);
            rd(`OFS_INT_STATUS, 1, 1, 1);
            bus(`OFS_CTRL, 1, 0);
            bus(`OFS_INT_STATUS, 1, 1);
            cmp({overflow_flag_a, irq}, 0, 0);
        end
        bus(`OFS_MODE, 1, 32'h33);
        bus(`OFS_COUNT_A, 1, 0);
        bus(`OFS_COUNT_B, 1, 32'h1234);
        bus(`OFS_CTRL, 1, 3);
        repeat (300) @(posedge core_clk);
        cmp(overflow_flag_b, 1, 1);
        rd(`OFS_COUNT_B, 32'h1234, 32'h1234, 32'hffff);
        bus(`OFS_CTRL, 1, 32'hc);
        {vector_ack_a, vector_ack_b} <= 2'b11;
        @(posedge core_clk);
        {vector_ack_a, vector_ack_b} <= 2'b00;
        @(posedge core_clk);
        cmp({overflow_flag_a, overflow_flag_b}, 0, 0);
        bus(`OFS_INT_STATUS, 1, 3);
        bus(`OFS_INT_MASK, 1, 3);
        for (int i = 0; i < 6; i++) begin
            v = $urandom_range(253, 255);
            bus(`OFS_CTRL, 1, 0);
            bus(`OFS_CLKCFG, 1, cf[i]);
            bus(`OFS_MODE, 1, 32'h22);
            bus(i < 4 ? `OFS_COUNT_A : `OFS_COUNT_B, 1, {v[7:0], v[7:0]});
            bus(`OFS_CTRL, 1, i < 4 ? 1 : 2);
            h = nn[i] / 2 * (256 - v);
            k = i < 4 ? 0 : (3 * h + 30) / h;
            b0 = nb;
            repeat (3 * h + 30) @(posedge core_clk);
            cmp(i < 4 ? half_a : half_b, h, h);
            cmp(nb - b0, k - (i > 3), k + (i > 3));
            cmp({i < 4 ? overflow_flag_a : overflow_flag_b, irq}, 2, 2);
            rd(`OFS_INT_STATUS, 0, 0, 3);
        end
        wrap_up();
    end
endmodule
